// *** hdl/rtc_calendar_trim_weekly_alarm.v ***
// Calendar chain (weekday, day, month, year), one-second timebase with
// count trim, and weekly alarm compare with its register file.
// Assumes a register port driven by the serial engine on mclk_i, and
// seconds/minute/hour values plus a day-rollover pulse from the time counters.
`timescale 1ns/1ps
`include "rtc_cal_consts.vh"

module rtc_calendar_trim_weekly_alarm (
  input wire mclk_i,
  input wire reset_n_i,
  input wire osc_clk_i,
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [6:0] seconds_i,
  input wire [6:0] minute_i,
  input wire [5:0] hour_i,
  input wire day_rollover_i,
  input wire power_up_flag_clear_i,
  output reg power_up_flag_o,
  output wire second_tick_o,
  output reg [2:0] weekday_o,
  output reg weekly_alarm_match_o
);

  // ==========================================================
  // Register state
  reg [7:0] day_of_month_count_r;
  reg [7:0] month_count_r;
  reg [7:0] year_count_r;
  reg [7:0] second_length_trim_r;
  reg [7:0] weekly_alarm_minute_r;
  reg [7:0] weekly_alarm_hour_r;
  reg [7:0] weekly_alarm_weekday_mask_r;

  wire wr_day = reg_wr_i && (reg_addr_i == `ADDR_DAY);
  wire wr_month = reg_wr_i && (reg_addr_i == `ADDR_MONTH);
  wire wr_year = reg_wr_i && (reg_addr_i == `ADDR_YEAR);
  wire wr_trim = reg_wr_i && (reg_addr_i == `ADDR_TRIM);
  wire wr_weekday = reg_wr_i && (reg_addr_i == `ADDR_WEEKDAY);

  // ==========================================================
  // BCD helpers
  // Steps one packed BCD byte: the units wrap 9 to 0 with a carry into the tens.
  // The tens digit is not range checked. A value the host should never write
  // may step into a non-BCD code, and the counters need not recover from it.
  // Keeping the helper that small keeps each counter's next-state logic shallow.
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Leap when the BCD year is a multiple of four, 00 included
  function is_leap;
    input [7:0] y;
    begin
      if (y[4] == 1'b0) begin
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
    end
  endfunction

  // ==========================================================
  // Calendar carry chain
  // Last valid day of the current month, in BCD, as a compare value.
  // The month is decoded from its stored BCD code, so 11 means November.
  // Months with no valid code fall into the 31-day branch; that is harmless,
  // because only existent months are ever loaded.
  reg [7:0] day_last;
  always @* begin
    case (month_count_r)
      8'h04, 8'h06, 8'h09, 8'h11: day_last = `DAY_LAST_30;
      8'h02: day_last = is_leap(year_count_r) ? `DAY_LAST_29 : `DAY_LAST_28;
      default: day_last = `DAY_LAST_31;
    endcase
  end

  // Carries ripple in one cycle: the day pulse, a day wrap and a month wrap
  // all fall on the same edge, so a host read never sees a half-updated date.
  // Equality is used rather than a compare, so a day past the month's end
  // keeps counting instead of wrapping; the host must not write one.
  wire day_wrap = day_rollover_i && (day_of_month_count_r == day_last);
  wire month_wrap = day_wrap && (month_count_r == `MONTH_LAST);

  // Host write wins over a carry landing in the same cycle
  // A carry that loses to a write is dropped, not deferred. This is the
  // expected effect when software sets the date across a midnight.
  // Each field is written on its own, so the month and year carries still
  // follow the old day value when only the day register is written.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      day_of_month_count_r <= `RST_DAY;
      month_count_r <= `RST_MONTH;
      year_count_r <= `RST_YEAR;
      weekday_o <= `RST_WEEKDAY;
    end else begin
      if (wr_day) begin
        day_of_month_count_r <= reg_wdata_i & `MASK_DAY;
      end else if (day_rollover_i) begin
        day_of_month_count_r <= day_wrap ? 8'h01 : bcd_inc(day_of_month_count_r);
      end
      if (wr_month) begin
        month_count_r <= reg_wdata_i & `MASK_MONTH;
      end else if (day_wrap) begin
        month_count_r <= month_wrap ? 8'h01 : bcd_inc(month_count_r);
      end
      if (wr_year) begin
        year_count_r <= reg_wdata_i;
      end else if (month_wrap) begin
        year_count_r <= (year_count_r == `YEAR_LAST) ? 8'h00 : bcd_inc(year_count_r);
      end
      if (wr_weekday) begin
        weekday_o <= reg_wdata_i[2:0];
      end else if (day_rollover_i) begin
        weekday_o <= (weekday_o == `WEEKDAY_LAST) ? 3'h0 : weekday_o + 3'h1;
      end
    end
  end

  // ==========================================================
  // Trim and alarm registers, power-up flag
  // Reset stands for the power-on-from-zero event
  // Only the trim value must come up at zero. The alarm fields are cleared as
  // well, so that no stale compare value can match before software loads it.
  // The power-up flag can only be cleared here; nothing but reset sets it.
  // The flag's clear input is a pulse on mclk_i from the serial engine.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      second_length_trim_r <= `RST_TRIM;
      weekly_alarm_minute_r <= `RST_ALM;
      weekly_alarm_hour_r <= `RST_ALM;
      weekly_alarm_weekday_mask_r <= `RST_ALM;
      power_up_flag_o <= 1'b1;
    end else begin
      if (wr_trim) begin
        second_length_trim_r <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_ALM_MIN)) begin
        weekly_alarm_minute_r <= reg_wdata_i & `MASK_ALM_MIN;
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_ALM_HOUR)) begin
        weekly_alarm_hour_r <= reg_wdata_i & `MASK_ALM_HOUR;
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_ALM_MASK)) begin
        weekly_alarm_weekday_mask_r <= reg_wdata_i & `MASK_ALM_MASK;
      end
      if (power_up_flag_clear_i) begin
        power_up_flag_o <= 1'b0;
      end
    end
  end

  // Registered read data; unmapped addresses return zero
  // The mux is one cycle behind the address. The serial engine therefore
  // presents the address one clock before it shifts the byte out.
  // Stored values are already masked, so unused bits read zero with no extra gating.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `ADDR_WEEKDAY: reg_rdata_o <= {5'h00, weekday_o};
        `ADDR_DAY: reg_rdata_o <= day_of_month_count_r;
        `ADDR_MONTH: reg_rdata_o <= month_count_r;
        `ADDR_YEAR: reg_rdata_o <= year_count_r;
        `ADDR_TRIM: reg_rdata_o <= second_length_trim_r;
        `ADDR_ALM_MIN: reg_rdata_o <= weekly_alarm_minute_r;
        `ADDR_ALM_HOUR: reg_rdata_o <= weekly_alarm_hour_r;
        `ADDR_ALM_MASK: reg_rdata_o <= weekly_alarm_weekday_mask_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Oscillator sampling: two stages, then edge detect on the second
  // The oscillator is far slower than mclk_i, so every one of its edges is seen.
  // All stages reset low, which is the oscillator's idle level. That avoids a
  // false edge right after reset; the first real rising edge counts normally.
  // Cost: each counted edge is seen two mclk_i cycles late, a fixed offset only.
  reg osc_s1_r;
  reg osc_s2_r;
  reg osc_s3_r;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_clk_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  wire osc_rise = osc_s2_r && !osc_s3_r;

  // ==========================================================
  // Second length: the oscillator itself is only counted, never altered
  wire trim_interval_select = second_length_trim_r[`TRIM_INTERVAL_BIT];
  wire trim_sign = second_length_trim_r[`TRIM_SIGN_BIT];
  wire [5:0] trim_magnitude = second_length_trim_r[`TRIM_MAG_MSB:`TRIM_MAG_LSB];

  // A write in the current second suppresses its adjustment
  // The flag is set by any trim write and is cleared at the end of each second.
  // A write in the very cycle of the tick keeps it set for the next second too.
  // That way an adjustment never applies a half-written trim value.
  reg trim_written_r;
  wire at_instant = (seconds_i == `SEC_00) ||
    (!trim_interval_select && ((seconds_i == `SEC_20) || (seconds_i == `SEC_40)));
  wire trim_now = at_instant && !trim_written_r && !wr_trim && (trim_magnitude != 6'h00);

  // Length of the running second in oscillator edges.
  // The largest positive trim gives 32768 + 124, and the largest negative one
  // gives 32768 - 126, so 17 bits always hold the result without overflow.
  // The value is taken from seconds_i as it stands at the second's last edge.
  reg [16:0] sec_len;
  always @* begin
    sec_len = `OSC_PER_SECOND;
    if (trim_now) begin
      if (!trim_sign) begin
        sec_len = `OSC_PER_SECOND + {10'h000, trim_magnitude - 6'h01, 1'b0};
      end else begin
        sec_len = `OSC_PER_SECOND - {10'h000, (~trim_magnitude) + 6'h01, 1'b0};
      end
    end
  end

  // Edge counter of the running second. It ends on reaching sec_len - 1, so one
  // second spans exactly sec_len edges. The compare is greater-or-equal, so a
  // shortening trim that lands after the count has already passed its new end
  // still closes the second at once, instead of running on for a full wrap.
  reg [16:0] osc_count_r;
  wire sec_end = osc_rise && (osc_count_r >= sec_len - 17'd1);
  assign second_tick_o = sec_end;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_count_r <= 17'd0;
      trim_written_r <= 1'b0;
    end else begin
      if (osc_rise) begin
        osc_count_r <= sec_end ? 17'd0 : osc_count_r + 17'd1;
      end
      // Set wins over the end-of-second clear
      if (wr_trim) begin
        trim_written_r <= 1'b1;
      end else if (sec_end) begin
        trim_written_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Weekly alarm compare; hour codes match as stored, so 12/32 work as is
  // No decoding of the 12/24-hour mode is needed, because the time counter
  // supplies its hour in the same coding as the alarm register.
  // Weekday code 7 is kept from matching, so a weekday register written as 7 never fires.
  // The match output stays high for as long as the inputs agree, one cycle late.
  wire mask_hit = weekly_alarm_weekday_mask_r[weekday_o];
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      weekly_alarm_match_o <= 1'b0;
    end else begin
      weekly_alarm_match_o <= mask_hit && (weekday_o != 3'h7) &&
        (minute_i == weekly_alarm_minute_r[6:0]) &&
        (hour_i == weekly_alarm_hour_r[5:0]);
    end
  end

endmodule

// *** hdl/rtc_cal_consts.vh ***
// Constants for the calendar, count-trim and weekly-alarm block.
// Included by the block's single design file; definitions only.
`ifndef RTC_CAL_CONSTS_VH
`define RTC_CAL_CONSTS_VH

// Register addresses on the internal register port
`define ADDR_WEEKDAY 4'h3
`define ADDR_DAY 4'h4
`define ADDR_MONTH 4'h5
`define ADDR_YEAR 4'h6
`define ADDR_TRIM 4'h7
`define ADDR_ALM_MIN 4'h8
`define ADDR_ALM_HOUR 4'h9
`define ADDR_ALM_MASK 4'ha

// Implemented bits per register; the rest read zero
`define MASK_WEEKDAY 8'h07
`define MASK_DAY 8'h3f
`define MASK_MONTH 8'h1f
`define MASK_YEAR 8'hff
`define MASK_TRIM 8'hff
`define MASK_ALM_MIN 8'h7f
`define MASK_ALM_HOUR 8'h3f
`define MASK_ALM_MASK 8'h7f

// Trim register fields
`define TRIM_INTERVAL_BIT 7
`define TRIM_SIGN_BIT 6
`define TRIM_MAG_MSB 5
`define TRIM_MAG_LSB 0

// Reset values
`define RST_TRIM 8'h00
`define RST_DAY 8'h01
`define RST_MONTH 8'h01
`define RST_YEAR 8'h00
`define RST_WEEKDAY 3'h0
`define RST_ALM 8'h00

// Calendar limits (BCD)
`define DAY_LAST_31 8'h31
`define DAY_LAST_30 8'h30
`define DAY_LAST_29 8'h29
`define DAY_LAST_28 8'h28
`define MONTH_LAST 8'h12
`define YEAR_LAST 8'h99
`define WEEKDAY_LAST 3'h6

// Trim instants (BCD seconds)
`define SEC_00 7'h00
`define SEC_20 7'h20
`define SEC_40 7'h40

// Oscillator cycles in one untrimmed second
`define OSC_PER_SECOND 17'd32768

`endif

// *** tb/rtc_cal_properties.sv ***
// Port checker for the calendar and weekly alarm block.
// Assumes binding to the design top; one clock domain.
`timescale 1ns/1ps
module rtc_cal_checker (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire day_rollover_i,
  input wire power_up_flag_clear_i,
  input wire power_up_flag_o,
  input wire [2:0] weekday_o,
  input wire weekly_alarm_match_o
);
  // ====
  // Shadow of the weekday mask, since the checker cannot see it
  reg [6:0] mask_r;
  wire wd_wr = reg_wr_i && reg_addr_i == 4'h3;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      mask_r <= 7'h00;
    else if (reg_wr_i && reg_addr_i == 4'ha)
      mask_r <= reg_wdata_i[6:0];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_mask_off;
    mask_r == 7'h00;
  endsequence
  a_unmapped_read: assert property (reg_addr_i < 4'h3 || reg_addr_i > 4'ha |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_day_bits: assert property (reg_addr_i == 4'h4 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("day read high bits set");
  a_month_bits: assert property (reg_addr_i == 4'h5 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("month read high bits set");
  a_hour_bits: assert property (reg_addr_i == 4'h9 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("alarm hour high bits set");
  a_weekday_wrap: assert property (day_rollover_i && weekday_o == 3'h6 && !wd_wr |=> weekday_o == 3'h0)
    else $error("weekday did not wrap");
  a_weekday_step: assert property (day_rollover_i && weekday_o < 3'h6 && !wd_wr |=> weekday_o == $past(weekday_o) + 3'h1)
    else $error("weekday did not step");
  a_weekday_hold: assert property (!day_rollover_i && !wd_wr |=> $stable(weekday_o))
    else $error("weekday moved without carry");
  a_flag_clear: assert property (power_up_flag_clear_i |=> !power_up_flag_o)
    else $error("power flag not cleared");
  a_flag_stays: assert property (!power_up_flag_o |=> !power_up_flag_o)
    else $error("power flag set again");
  a_mask_zero: assert property (s_mask_off [*2] |=> !weekly_alarm_match_o)
    else $error("match with empty mask");
endmodule
bind rtc_calendar_trim_weekly_alarm rtc_cal_checker rtc_cal_checker_inst (.mclk_i, .reset_n_i, .reg_addr_i,
  .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .day_rollover_i, .power_up_flag_clear_i, .power_up_flag_o,
  .weekday_o, .weekly_alarm_match_o);

// *** tb/rtc_host_model.sv ***
// Host side model: register writes and reads on the block's port.
// Assumes tasks are called by the bench; drives on falling edges.
`timescale 1ns/1ps
module rtc_host_model (
  input wire mclk_i,
  input wire [7:0] rdata_i,
  output reg [3:0] addr_o = 4'h0,
  output reg wr_o = 1'b0,
  output reg [7:0] wdata_o = 8'h00
);
  // ====
  // One strobe cycle; data then goes to its inverse so stale data is never read as valid
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge mclk_i);
      addr_o = a;
      wr_o = 1'b1;
      wdata_o = d;
      @(negedge mclk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
    end
  endtask
  // Read data is registered, so it is taken a cycle later
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(negedge mclk_i);
      addr_o = a;
      @(negedge mclk_i);
      d = rdata_i;
    end
  endtask
endmodule

// *** tb/rtc_calendar_trim_weekly_alarm_bench.sv ***
// Bench for the calendar, trim register and weekly alarm block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module rtc_calendar_trim_weekly_alarm_bench;
  reg mclk_i = 1'b0;
  reg osc_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg day_rollover_i = 1'b0;
  reg power_up_flag_clear_i = 1'b0;
  reg [6:0] minute_i = 7'h30;
  reg [6:0] seconds_i = 7'h00;
  reg [5:0] hour_i = 6'h32;
  wire [3:0] reg_addr_i;
  wire reg_wr_i, power_up_flag_o, second_tick_o, weekly_alarm_match_o;
  wire [7:0] reg_wdata_i, reg_rdata_o;
  wire [2:0] weekday_o;
  integer miscompares = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] v;
  reg [2:0] wd_exp = 3'h0;
  reg [47:0] cal [0:6];
  // ====
  // Clocks; the oscillator is free running
  always #12.5 mclk_i = ~mclk_i;
  always #100 osc_clk_i = ~osc_clk_i;
  rtc_calendar_trim_weekly_alarm rtc_calendar_trim_weekly_alarm_inst (.mclk_i, .reset_n_i, .osc_clk_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .seconds_i, .minute_i, .hour_i,
    .day_rollover_i, .power_up_flag_clear_i, .power_up_flag_o, .second_tick_o, .weekday_o,
    .weekly_alarm_match_o);
  rtc_host_model rtc_host_model_inst (.mclk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .wdata_o(reg_wdata_i));
  task end_of_test;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task rdc(input [3:0] a, input [7:0] e, input string n);
    begin
      rtc_host_model_inst.rd(a, v);
      chk(n, e, v);
    end
  endtask
  // Loads an alarm and checks the match two cycles on
  task alm(input [7:0] h, input [7:0] m, input [7:0] e);
    begin
      rtc_host_model_inst.wr(4'h9, h);
      rtc_host_model_inst.wr(4'ha, m);
      repeat (2) @(negedge mclk_i);
      chk("match", e, {7'h00, weekly_alarm_match_o});
    end
  endtask
  // Hang guard, far beyond the roughly 150 cycles needed
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  // Start date day/month/year, then expected date after one rollover
  initial begin
    cal[0] = 48'h28_02_01_01_03_01;
    cal[1] = 48'h28_02_04_29_02_04;
    cal[2] = 48'h28_02_00_29_02_00;
    cal[3] = 48'h30_04_05_01_05_05;
    cal[4] = 48'h30_01_05_31_01_05;
    cal[5] = 48'h31_12_99_01_01_00;
    cal[6] = 48'h09_10_19_10_10_19;
    repeat (12) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk("flag", 8'h01, {7'h00, power_up_flag_o});
    rdc(4'h7, 8'h00, "trim");
    rtc_host_model_inst.wr(4'h7, 8'hfe);
    rdc(4'h7, 8'hfe, "trim");
    rtc_host_model_inst.wr(4'h4, 8'hff);
    rdc(4'h4, 8'h3f, "day");
    rdc(4'h2, 8'h00, "unmapped");
    power_up_flag_clear_i = 1'b1;
    @(negedge mclk_i);
    power_up_flag_clear_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("flag", 8'h00, {7'h00, power_up_flag_o});
    for (i = 0; i < 7; i = i + 1) begin
      rtc_host_model_inst.wr(4'h4, cal[i][47:40]);
      rtc_host_model_inst.wr(4'h5, cal[i][39:32]);
      rtc_host_model_inst.wr(4'h6, cal[i][31:24]);
      day_rollover_i = 1'b1;
      @(negedge mclk_i);
      day_rollover_i = 1'b0;
      wd_exp = (wd_exp == 3'h6) ? 3'h0 : wd_exp + 3'h1;
      rdc(4'h4, cal[i][23:16], "day");
      rdc(4'h5, cal[i][15:8], "month");
      rdc(4'h6, cal[i][7:0], "year");
      chk("weekday", {5'h00, wd_exp}, {5'h00, weekday_o});
    end
    rtc_host_model_inst.wr(4'h8, 8'h30);
    alm(8'h32, 8'h7f, 8'h01);
    alm(8'h12, 8'h7f, 8'h00);
    rtc_host_model_inst.wr(4'h3, 8'h04);
    alm(8'h32, 8'h10, 8'h01);
    alm(8'h32, 8'h6f, 8'h00);
    alm(8'h32, 8'h00, 8'h00);
    chk("tick", 8'h00, {7'h00, second_tick_o});
    end_of_test;
  end
endmodule
